// ---- hdl/stack_ram_core.v ----
`timescale 1ns/100ps
// Notes on behaviour
// [RULE_01] call pushes return pointer; interrupt acceptance pushes pointer and flags.
// [RULE_02] subroutine return restores pointer only; interrupt return restores flags too.
// [RULE_03] stack holds up to 15 locations, 0 to 14, in upper memory.
// [RULE_04] each location is four consecutive nibbles holding one context.
// [RULE_05] location pointer decrements after each save, increments before each restore.
// [RULE_06] pointer always names the location used by the next save.
// [RULE_07] pointer lives in topmost memory word, readable and writable as ram.
// [RULE_08] locations 13 and 14 overlap the two timer count registers.
// [RULE_09] software never writes 15 into the location pointer.
// [RULE_10] pointer not reset by hardware; software initialises it, usually to 12.
// [RULE_11] no overflow guard; excess saves overwrite user data.
// [RULE_12] 12-bit table counter addresses program memory for both lookup halves.
// [RULE_13] table counter sits in three nibbles, low at 7c, high at 7e.
// [RULE_14] timer count registers are ram nibbles, set and read by ram access.
// [RULE_15] software starts stack at 13 or 14 only with timers unused.
// [RULE_16] words 77 and 7b stay free data when both timers run.
// [RULE_17] bottom 16 words reachable through zero-page addressing.
// [RULE_18] memory contents undefined at power-on, never cleared by hardware.
// [RULE_19] timer one count at 74-76, timer two count at 78-7a.
// [RULE_20] saved flags are carry, zero, branch condition and general flags.
// [RULE_21] saved return address is the full 11-bit instruction pointer.
`include "stack_ram_map.vh"

module stack_ram_core #(
  parameter RAM_WORDS = `RAM_WORDS_LARGE
) (
  input wire ref_clk,
  input wire rst_n,
  input wire ram_req,
  input wire ram_wr,
  input wire ram_zero_page,
  input wire [6:0] ram_addr,
  input wire [3:0] ram_wdata,
  output reg [3:0] ram_rdata_q,
  output reg ram_ack_q,
  input wire call_req,
  input wire intr_req,
  input wire subroutine_return,
  input wire interrupt_return,
  input wire [10:0] instruction_pointer,
  input wire carry_flag_bit,
  input wire zero_flag_bit,
  input wire branch_condition_flag,
  input wire general_purpose_flag,
  output reg stack_busy_q,
  output reg stack_done_q,
  output reg [10:0] restored_pointer_q,
  output reg [3:0] restored_flags_q,
  output reg flags_valid_q,
  input wire table_lookup_low,
  input wire table_lookup_high,
  output reg [11:0] table_address_q,
  output reg table_valid_q,
  input wire timer_one_load,
  input wire [11:0] timer_one_value,
  input wire timer_two_load,
  input wire [11:0] timer_two_value,
  output reg [11:0] timer_one_count_q,
  output reg [11:0] timer_two_count_q
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // memory and fixed views of it
  // ----------------------------------------
  localparam [31:0] AMASK_FULL = RAM_WORDS - 1;
  localparam [6:0] AMASK = AMASK_FULL[6:0];
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_SAVE = 2'd1;
  localparam [1:0] S_PTR = 2'd2;

  wire [4*RAM_WORDS-1:0] contents;
  reg mem_we;
  reg [6:0] mem_waddr;
  reg [3:0] mem_wdata;
  reg tri_we;
  reg [6:0] tri_base;
  reg [11:0] tri_data;

  wire [6:0] ptr_addr = `ADDR_STACK_PTR & AMASK; // [RULE_07]
  wire [6:0] tbl_addr = `ADDR_TBL_LOW & AMASK; // [RULE_13]
  wire [6:0] tmr1_addr = `ADDR_TMR1_LOW & AMASK; // [RULE_19]
  wire [6:0] tmr2_addr = `ADDR_TMR2_LOW & AMASK; // [RULE_19]
  wire [6:0] mid_addr = `ADDR_TBL_MID & AMASK;
  wire [6:0] high_addr = `ADDR_TBL_HIGH & AMASK;

  wire [3:0] stack_location_pointer = contents[{ptr_addr, 2'b00} +: 4];
  wire [11:0] table_address_counter = {contents[{high_addr, 2'b00} +: 4],
    contents[{mid_addr, 2'b00} +: 4], contents[{tbl_addr, 2'b00} +: 4]}; // [RULE_12]
  wire [11:0] tmr1_word = {contents[{tmr1_addr + 7'd2, 2'b00} +: 4],
    contents[{tmr1_addr + 7'd1, 2'b00} +: 4], contents[{tmr1_addr, 2'b00} +: 4]}; // [RULE_14]
  wire [11:0] tmr2_word = {contents[{tmr2_addr + 7'd2, 2'b00} +: 4],
    contents[{tmr2_addr + 7'd1, 2'b00} +: 4], contents[{tmr2_addr, 2'b00} +: 4]}; // [RULE_14]

  nibble_ram #(
    .WORDS(RAM_WORDS),
    .AW(`ADDR_W)
  ) u_ram (
    .clk(ref_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .tri_we(tri_we),
    .tri_base(tri_base),
    .tri_data(tri_data),
    .contents(contents)
  );

  // ----------------------------------------
  // stack sequencer state
  // ----------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] loc_q; // [RULE_03]
  reg [1:0] nib_q;
  reg [1:0] last_nib_q;
  reg [14:0] ctx_q;
  reg restore_go;
  reg save_go;
  reg [3:0] rest_loc;
  reg [14:0] rest_ctx;
  reg [3:0] save_nib;

  wire [3:0] flags_now = {carry_flag_bit, zero_flag_bit,
    branch_condition_flag, general_purpose_flag}; // [RULE_20]
  wire idle = (state_q == S_IDLE);
  wire any_stack = call_req | intr_req | subroutine_return | interrupt_return;
  wire cpu_take = idle & ~any_stack & ram_req;
  wire [6:0] cpu_addr = ram_zero_page ? {3'b000, ram_addr[3:0]} : ram_addr; // [RULE_17]
  wire [6:0] cpu_addr_m = cpu_addr & AMASK;
  // location n nibble k sits at base + 4n + k, no bound check
  wire [6:0] save_addr = (`ADDR_STACK_BASE | {1'b0, loc_q, nib_q}) & AMASK; // [RULE_04] [RULE_11]

  // ----------------------------------------
  // restore: pre-increment then read location
  // ----------------------------------------
  always @* begin
    rest_loc = stack_location_pointer + 4'h1; // [RULE_05]
    rest_ctx[3:0] = contents[{(`ADDR_STACK_BASE | {1'b0, rest_loc, 2'd0}) & AMASK, 2'b00} +: 4];
    rest_ctx[7:4] = contents[{(`ADDR_STACK_BASE | {1'b0, rest_loc, 2'd1}) & AMASK, 2'b00} +: 4];
    rest_ctx[10:8] = contents[{(`ADDR_STACK_BASE | {1'b0, rest_loc, 2'd2}) & AMASK, 2'b00} +: 3];
    rest_ctx[14:11] = contents[{(`ADDR_STACK_BASE | {1'b0, rest_loc, 2'd3}) & AMASK, 2'b00} +: 4];
  end

  always @* begin
    case (nib_q)
      2'd0: save_nib = ctx_q[3:0];
      2'd1: save_nib = ctx_q[7:4];
      2'd2: save_nib = {1'b0, ctx_q[10:8]};
      default: save_nib = ctx_q[14:11];
    endcase
  end

  // ----------------------------------------
  // single nibble write port arbitration
  // ----------------------------------------
  always @* begin
    mem_we = 1'b0;
    mem_waddr = 7'h00;
    mem_wdata = 4'h0;
    save_go = 1'b0;
    restore_go = 1'b0;
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (call_req | intr_req) begin
          save_go = 1'b1;
          state_d = S_SAVE;
        end else if (subroutine_return | interrupt_return) begin
          restore_go = 1'b1;
          mem_we = 1'b1;
          mem_waddr = ptr_addr;
          mem_wdata = rest_loc; // [RULE_05]
        end else if (cpu_take & ram_wr) begin
          mem_we = 1'b1;
          mem_waddr = cpu_addr_m;
          mem_wdata = ram_wdata;
        end
      end
      S_SAVE: begin
        mem_we = 1'b1;
        mem_waddr = save_addr;
        mem_wdata = save_nib;
        if (nib_q == last_nib_q) begin
          state_d = S_PTR;
        end
      end
      S_PTR: begin
        mem_we = 1'b1;
        mem_waddr = ptr_addr;
        mem_wdata = loc_q - 4'h1; // [RULE_05] [RULE_06]
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // table counter increment and timer loads
  // ----------------------------------------
  reg tmr1_pend_q;
  reg tmr2_pend_q;
  reg [11:0] tmr1_val_q;
  reg [11:0] tmr2_val_q;
  wire tbl_inc = table_lookup_high & ~mem_we;
  wire tmr1_go = tmr1_pend_q & ~tbl_inc;
  wire tmr2_go = tmr2_pend_q & ~tbl_inc & ~tmr1_go;

  always @* begin
    tri_we = 1'b0;
    tri_base = tbl_addr;
    tri_data = table_address_counter + 12'h001;
    if (tbl_inc) begin
      tri_we = 1'b1;
    end else if (tmr1_go) begin
      tri_we = 1'b1;
      tri_base = tmr1_addr; // [RULE_08]
      tri_data = tmr1_val_q;
    end else if (tmr2_go) begin
      tri_we = 1'b1;
      tri_base = tmr2_addr; // [RULE_08]
      tri_data = tmr2_val_q;
    end
  end

  always @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tmr1_pend_q <= 1'b0;
      tmr2_pend_q <= 1'b0;
      tmr1_val_q <= 12'h000;
      tmr2_val_q <= 12'h000;
    end else begin
      if (timer_one_load) begin
        tmr1_pend_q <= 1'b1;
        tmr1_val_q <= timer_one_value;
      end else if (tmr1_go) begin
        tmr1_pend_q <= 1'b0;
      end
      if (timer_two_load) begin
        tmr2_pend_q <= 1'b1;
        tmr2_val_q <= timer_two_value;
      end else if (tmr2_go) begin
        tmr2_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // sequencer and output registers
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= S_IDLE;
      loc_q <= 4'h0;
      nib_q <= 2'd0;
      last_nib_q <= 2'd0;
      ctx_q <= 15'h0000;
      stack_busy_q <= 1'b0;
      stack_done_q <= 1'b0;
      restored_pointer_q <= 11'h000;
      restored_flags_q <= 4'h0;
      flags_valid_q <= 1'b0;
      ram_rdata_q <= 4'h0;
      ram_ack_q <= 1'b0;
      table_address_q <= 12'h000;
      table_valid_q <= 1'b0;
      timer_one_count_q <= 12'h000;
      timer_two_count_q <= 12'h000;
    end else begin
      state_q <= state_d;
      stack_done_q <= 1'b0;
      flags_valid_q <= 1'b0;
      ram_ack_q <= 1'b0;
      table_valid_q <= 1'b0;
      timer_one_count_q <= tmr1_word;
      timer_two_count_q <= tmr2_word;
      if (save_go) begin
        loc_q <= stack_location_pointer; // [RULE_06]
        nib_q <= 2'd0;
        ctx_q <= {flags_now, instruction_pointer}; // [RULE_21]
        last_nib_q <= intr_req ? `INTR_NIBBLES : `CALL_NIBBLES; // [RULE_01]
        stack_busy_q <= 1'b1;
      end else if (state_q == S_SAVE) begin
        nib_q <= nib_q + 2'd1;
      end else if (state_q == S_PTR) begin
        stack_busy_q <= 1'b0;
        stack_done_q <= 1'b1;
      end
      if (restore_go) begin
        restored_pointer_q <= rest_ctx[10:0]; // [RULE_02]
        stack_done_q <= 1'b1;
        if (interrupt_return) begin
          restored_flags_q <= rest_ctx[14:11]; // [RULE_02] [RULE_20]
          flags_valid_q <= 1'b1;
        end
      end
      if (cpu_take) begin
        ram_ack_q <= 1'b1;
        ram_rdata_q <= contents[{cpu_addr_m, 2'b00} +: 4]; // [RULE_07] [RULE_16]
      end
      if (table_lookup_low | table_lookup_high) begin
        table_address_q <= table_address_counter; // [RULE_12]
        table_valid_q <= 1'b1;
      end
    end
  end
endmodule

// ---- pkg/stack_ram_map.vh ----
`ifndef STACK_RAM_MAP_VH
`define STACK_RAM_MAP_VH

// ----------------------------------------
// address map of the special ram areas
// ----------------------------------------
`define ADDR_W 7
`define ADDR_STACK_PTR 7'h7f
`define ADDR_TBL_LOW 7'h7c
`define ADDR_TBL_MID 7'h7d
`define ADDR_TBL_HIGH 7'h7e
`define ADDR_TMR1_LOW 7'h74
`define ADDR_TMR2_LOW 7'h78
`define ADDR_TMR1_SPARE 7'h77
`define ADDR_TMR2_SPARE 7'h7b
`define ADDR_STACK_BASE 7'h40
`define ADDR_ZERO_PAGE 7'h00

// ----------------------------------------
// sizes and field layout
// ----------------------------------------
`define RAM_WORDS_LARGE 128
`define RAM_WORDS_SMALL 64
`define STACK_LOCATIONS 15
`define STACK_LAST_LOC 4'he
`define STACK_INIT_HINT 4'hc
`define WORDS_PER_LOC 4
`define TBL_W 12
`define IP_W 11
`define FLAG_W 4
`define FLAG_GENERAL 0
`define FLAG_BRANCH 1
`define FLAG_ZERO 2
`define FLAG_CARRY 3
`define CALL_NIBBLES 2'd2
`define INTR_NIBBLES 2'd3

`endif

// ---- hdl/nibble_ram.v ----
`timescale 1ns/100ps
// ----------------------------------------
// nibble wide data memory, not cleared
// ----------------------------------------
module nibble_ram #(
  parameter WORDS = 128,
  parameter AW = 7
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [3:0] wdata,
  input wire tri_we,
  input wire [AW-1:0] tri_base,
  input wire [11:0] tri_data,
  output wire [4*WORDS-1:0] contents
);
  localparam [31:0] WMASK_FULL = WORDS - 1;
  reg [3:0] mem [0:WORDS-1];
  wire [AW-1:0] one_step;
  wire [AW-1:0] tri_a1;
  wire [AW-1:0] tri_a2;
  wire [AW-1:0] wmask;
  genvar gi;

  assign one_step = {{(AW-1){1'b0}}, 1'b1};
  assign wmask = WMASK_FULL[AW-1:0];
  assign tri_a1 = (tri_base + one_step) & wmask;
  assign tri_a2 = (tri_base + one_step + one_step) & wmask;

  generate
    for (gi = 0; gi < WORDS; gi = gi + 1) begin : g_flat
      assign contents[4*gi +: 4] = mem[gi];
    end
  endgenerate

  // no reset: contents are unknown after power-on
  always @(posedge clk) begin // [RULE_18]
    if (tri_we) begin
      mem[tri_base & wmask] <= tri_data[3:0];
      mem[tri_a1] <= tri_data[7:4];
      mem[tri_a2] <= tri_data[11:8];
    end
    if (we) begin
      mem[waddr & wmask] <= wdata;
    end
  end
endmodule

// ---- test/stack_ram_props.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// port checks
// ----------------------------------------
module stack_ram_props #(
  parameter RAM_WORDS = 128
) (
  input wire ref_clk,
  input wire rst_n,
  input wire ram_req,
  input wire ram_ack_q,
  input wire call_req,
  input wire intr_req,
  input wire subroutine_return,
  input wire interrupt_return,
  input wire stack_busy_q,
  input wire stack_done_q,
  input wire flags_valid_q,
  input wire [3:0] restored_flags_q,
  input wire table_lookup_low,
  input wire table_lookup_high,
  input wire table_valid_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire idle = !stack_busy_q && !call_req && !intr_req;
  a_call_save_seq: assert property (call_req && !intr_req && !stack_busy_q
    |=> stack_busy_q [*4] ##1 (stack_done_q && !stack_busy_q)) else $error("call save timing");
  a_intr_save_seq: assert property (intr_req && !stack_busy_q
    |=> stack_busy_q [*5] ##1 (stack_done_q && !stack_busy_q)) else $error("intr save timing");
  a_return_done: assert property ((subroutine_return || interrupt_return) && idle
    |=> stack_done_q && !stack_busy_q) else $error("restore timing");
  a_flags_pulse_cause: assert property (flags_valid_q
    |-> stack_done_q && $past(interrupt_return)) else $error("flags valid without return");
  a_flags_hold: assert property (!$past(interrupt_return)
    |-> $stable(restored_flags_q)) else $error("flags changed");
  a_ram_answer: assert property (ram_req && idle && !subroutine_return
    && !interrupt_return |=> ram_ack_q) else $error("ram access not answered");
  a_ram_refuse: assert property (ram_ack_q
    |-> $past(ram_req) && !$past(stack_busy_q)) else $error("ack without taken access");
  a_table_answer: assert property (table_lookup_low || table_lookup_high
    |=> table_valid_q) else $error("lookup not answered");
  a_table_cause: assert property (table_valid_q
    |-> $past(table_lookup_low || table_lookup_high)) else $error("lookup valid unasked");
  cover property (intr_req && !stack_busy_q);
  cover property (flags_valid_q);
  cover property (table_valid_q);
endmodule
bind stack_ram_core stack_ram_props #(.RAM_WORDS(RAM_WORDS)) i_props (.*);

// ---- test/cpu_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// cpu side of the ram bus
// ----------------------------------------
module cpu_model (
  input wire ref_clk,
  input wire [3:0] ram_rdata_q,
  input wire ram_ack_q,
  output logic ram_req = 1'b0,
  output logic ram_wr = 1'b0,
  output logic ram_zero_page = 1'b0,
  output logic [6:0] ram_addr = 7'h00,
  output logic [3:0] ram_wdata = 4'h0
);
  task automatic access(input logic wr, input logic zp, input logic [6:0] a,
                        input logic [3:0] d, output logic [3:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    ram_req <= 1'b1;
    ram_wr <= wr;
    ram_zero_page <= zp;
    ram_addr <= a;
    ram_wdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ram_ack_q !== 1'b1 && n < 20);
    q = ram_rdata_q;
    ram_req <= 1'b0;
    ram_wdata <= ~d;
  endtask
  // pointer starts at 12, never 15, timer words left alone
  task automatic start_stack();
    logic [3:0] q;
    access(1'b1, 1'b0, 7'h7f, 4'hc, q);
  endtask
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// self checking bench
// ----------------------------------------
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic call_req = 1'b0;
  logic intr_req = 1'b0;
  logic subroutine_return = 1'b0;
  logic interrupt_return = 1'b0;
  logic [10:0] instruction_pointer = 11'h000;
  logic carry_flag_bit = 1'b0;
  logic zero_flag_bit = 1'b0;
  logic branch_condition_flag = 1'b0;
  logic general_purpose_flag = 1'b0;
  logic table_lookup_low = 1'b0;
  logic table_lookup_high = 1'b0;
  logic timer_one_load = 1'b0;
  logic timer_two_load = 1'b0;
  logic [11:0] timer_one_value = 12'h000;
  logic [11:0] timer_two_value = 12'h000;
  wire ram_req, ram_wr, ram_zero_page, ram_ack_q, stack_busy_q, stack_done_q;
  wire flags_valid_q, table_valid_q;
  wire [6:0] ram_addr;
  wire [3:0] ram_wdata, ram_rdata_q, restored_flags_q;
  wire [10:0] restored_pointer_q;
  wire [11:0] table_address_q, timer_one_count_q, timer_two_count_q;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h4;
  logic [3:0] mem [0:127];
  logic [3:0] ef = 4'h0;
  logic [14:0] saved [$];
  logic [31:0] r;
  logic [3:0] q;

  stack_ram_core #(.RAM_WORDS(128)) i_dut (.*);
  cpu_model i_cpu (.*);

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      close_out();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    logic [3:0] v;
    i_cpu.access(1'b1, 1'b0, a, d, v);
    mem[a] = d;
  endtask
  task automatic rd(input logic [6:0] a, input int n);
    logic [3:0] v;
    for (int i = 0; i < n; i++) begin
      i_cpu.access(1'b0, 1'b0, a + 7'(i), 4'h0, v);
      chk("ram nibble", {8'h00, v}, {8'h00, mem[a + 7'(i)]});
    end
  endtask
  // kind: 0 call, 1 interrupt, 2 return, 3 interrupt return
  task automatic step(input int kind);
    logic [31:0] x;
    logic [6:0] b;
    int n;
    x = rnd();
    @(posedge ref_clk);
    instruction_pointer <= x[10:0];
    {carry_flag_bit, zero_flag_bit, branch_condition_flag, general_purpose_flag} <= x[14:11];
    call_req <= kind == 0;
    intr_req <= kind == 1;
    subroutine_return <= kind == 2;
    interrupt_return <= kind == 3;
    @(posedge ref_clk);
    {call_req, intr_req, subroutine_return, interrupt_return} <= 4'h0;
    n = 0;
    while (stack_done_q !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    chk("done delay", 12'(n), kind == 0 ? 12'h5 : kind == 1 ? 12'h6 : 12'h1);
    if (kind < 2) begin
      b = 7'h40 + {1'b0, mem[127], 2'b00};
      mem[b] = x[3:0];
      mem[b + 7'h1] = x[7:4];
      mem[b + 7'h2] = {1'b0, x[10:8]};
      if (kind == 1) mem[b + 7'h3] = x[14:11];
      mem[127] = mem[127] - 4'h1;
      saved.push_back(x[14:0]);
    end else begin
      mem[127] = mem[127] + 4'h1;
      x[14:0] = saved.pop_back();
      if (kind == 3) ef = x[14:11];
      chk("restored pointer", {1'b0, restored_pointer_q}, {1'b0, x[10:0]});
      chk("restored flags", {8'h00, restored_flags_q}, {8'h00, ef});
      chk("flags valid", {11'h0, flags_valid_q}, {11'h0, kind == 3});
    end
  endtask
  task automatic lookup(input logic hi);
    logic [11:0] old;
    old = {mem[126], mem[125], mem[124]};
    @(posedge ref_clk);
    table_lookup_low <= !hi;
    table_lookup_high <= hi;
    @(posedge ref_clk);
    table_lookup_low <= 1'b0;
    table_lookup_high <= 1'b0;
    @(posedge ref_clk);
    chk("table address", table_address_q, old);
    {mem[126], mem[125], mem[124]} = old + {11'h0, hi};
    rd(7'h7c, 3);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    i_cpu.start_stack();
    mem[127] = 4'hc;
    r = rnd();
    for (int i = 0; i < 3; i++) wr(7'h7c + 7'(i), r[4*i +: 4]);
    rd(7'h7c, 4);
    wr(7'h7c, 4'hf);
    wr(7'h7d, 4'hf);
    for (int k = 0; k < 2; k++) lookup(k[0]);
    step(0);
    step(1);
    step(0);
    rd(7'h68, 3);
    rd(7'h6c, 7);
    rd(7'h7f, 1);
    step(2);
    step(3);
    step(2);
    rd(7'h7f, 1);
    r = rnd();
    @(posedge ref_clk);
    timer_one_value <= r[11:0];
    timer_two_value <= r[27:16];
    {timer_one_load, timer_two_load} <= 2'b11;
    @(posedge ref_clk);
    {timer_one_load, timer_two_load} <= 2'b00;
    repeat (4) @(posedge ref_clk);
    {mem[118], mem[117], mem[116]} = r[11:0];
    {mem[122], mem[121], mem[120]} = r[27:16];
    chk("timer one count", timer_one_count_q, r[11:0]);
    chk("timer two count", timer_two_count_q, r[27:16]);
    wr(7'h77, r[31:28]);
    wr(7'h7b, ~r[31:28]);
    rd(7'h74, 8);
    wr(7'h7f, 4'he);
    step(0);
    repeat (2) @(posedge ref_clk);
    chk("timer two shared", timer_two_count_q, {mem[122], mem[121], mem[120]});
    rd(7'h78, 3);
    step(2);
    i_cpu.access(1'b1, 1'b1, 7'h35, r[7:4], q);
    mem[5] = r[7:4];
    rd(7'h05, 1);
    rd(7'h7f, 1);
    close_out();
  end
endmodule
